// ==== src/bmi_slave.sv ====
// Two-wire serial slave port of the battery monitor
`default_nettype none
module bmi_slave
   import bmi_pkg::*;
#(
   parameter int WR_CYCLES = bmi_pkg::BMI_WR_CYCLES
) (
   // System clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // Link sampling clock
   input  wire logic       link_clk,
   input  wire logic       link_rst_n,
   // Device state
   input  wire logic       powerdown,
   input  wire logic       addr_strap,
   // Bus pins
   input  wire logic       scl_pin,
   input  wire logic       serial_data_in_pin,
   output var  logic       serial_data_out_pin,
   // Register store access (link clock)
   output var  logic [7:0] reg_addr,
   output var  logic [7:0] reg_wdata,
   output var  logic       reg_we,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_protected,
   // Status
   output var  logic       write_busy
);
   import bmi_pkg::*;

   logic       scl_s;
   logic       sda_s;
   logic       scl_d_r;
   logic       sda_d_r;
   logic       en_r;
   logic [2:0] en_sync_r;
   logic [2:0] busy_sync_r;
   logic       strap_r;
   bmi_state_t state_r;
   bmi_state_t state_nxt;
   logic [2:0] bit_r;
   logic [7:0] shift_r;
   logic [7:0] ptr_r;
   logic       rd_r;
   logic       ack_r;
   logic       wrote_r;
   logic       sda_out_r;
   logic       tgl_r;
   logic       first_r;
   logic       data_r;
   logic       dwr_r;
   logic       start_ev;
   logic       stop_ev;
   logic       scl_rise;
   logic       scl_fall;
   logic       port_on;
   logic       busy;

   bmi_sync #(.INIT(1'b1)) u_scl (
      .clk   (link_clk),
      .rst_n (link_rst_n),
      .din   (scl_pin),
      .dout  (scl_s)
   );
   bmi_sync #(.INIT(1'b1)) u_sda (
      .clk   (link_clk),
      .rst_n (link_rst_n),
      .din   (serial_data_in_pin),
      .dout  (sda_s)
   );
   bmi_wcycle #(.CYCLES(WR_CYCLES)) u_wc (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .start_tgl (tgl_r),
      .busy      (busy)
   );
   assign write_busy = busy;

   // Enable level in system domain, crossed to link domain
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         en_r <= 1'b0;
      end else begin
         en_r <= !powerdown;
      end
   end
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         en_sync_r   <= 3'h0;
         busy_sync_r <= 3'h0;
      end else begin
         en_sync_r   <= {en_sync_r[1:0], en_r};
         busy_sync_r <= {busy_sync_r[1:0], busy};
      end
   end
   assign port_on = en_sync_r[2] && (en_sync_r[1] == en_sync_r[2]) && !busy_sync_r[2];

   // Strap caught whenever the port is off: after reset release, in powerdown and during a write cycle
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         strap_r <= 1'b0;
      end else if (!port_on) begin
         strap_r <= addr_strap;
      end
   end

   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end
   assign start_ev = port_on && scl_s && scl_d_r && sda_d_r && !sda_s;
   assign stop_ev  = scl_s && scl_d_r && !sda_d_r && sda_s;
   assign scl_rise = scl_s && !scl_d_r;
   assign scl_fall = !scl_s && scl_d_r;

   // Bus state machine, advanced on falling clock edges
   always_comb begin
      state_nxt = state_r;
      if (!port_on) begin
         state_nxt = BMI_IDLE;
      end else if (start_ev) begin
         state_nxt = BMI_DEV_ADDR;
      end else if (stop_ev) begin
         state_nxt = BMI_IDLE;
      end else if (scl_fall) begin
         unique case (state_r)
            BMI_IDLE, BMI_IGNORE: begin
               state_nxt = state_r;
            end
            BMI_DEV_ADDR: begin
               if (bit_r == BMI_LAST_BIT) begin
                  state_nxt = ack_r ? BMI_ACK_OUT : BMI_IGNORE;
               end
            end
            BMI_REG_ADDR, BMI_WR_DATA: begin
               if (bit_r == BMI_LAST_BIT) begin
                  state_nxt = ack_r ? BMI_ACK_OUT : BMI_IGNORE;
               end
            end
            BMI_ACK_OUT: begin
               if (rd_r) begin
                  state_nxt = BMI_RD_DATA;
               end else if (wrote_r) begin
                  state_nxt = BMI_WR_DATA;
               end else begin
                  state_nxt = BMI_REG_ADDR;
               end
            end
            BMI_RD_DATA: begin
               if (bit_r == BMI_LAST_BIT) begin
                  state_nxt = BMI_ACK_IN;
               end
            end
            BMI_ACK_IN: begin
               state_nxt = ack_r ? BMI_RD_DATA : BMI_IGNORE;
            end
         endcase
      end
   end
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         state_r <= BMI_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // The clock fall that closes a start carries no bit, so it is not counted
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         first_r <= 1'b0;
      end else if (start_ev) begin
         first_r <= 1'b1;
      end else if (scl_rise) begin
         first_r <= 1'b0;
      end
   end

   // Bit counter and receive shifter, MSB first
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         bit_r   <= 3'h0;
         shift_r <= 8'h00;
      end else if (start_ev || (scl_fall && state_r inside {BMI_ACK_OUT, BMI_ACK_IN})) begin
         bit_r <= 3'h0;
      end else if (scl_rise) begin
         shift_r <= {shift_r[6:0], sda_s};
      end else if (scl_fall && !first_r) begin
         bit_r <= bit_r + 3'h1;
      end
   end

   // Decision on ack for received bytes and master ack on reads
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         ack_r <= 1'b0;
         rd_r  <= 1'b0;
      end else if (scl_rise && state_r == BMI_ACK_IN) begin
         ack_r <= !sda_s;
      end else if (scl_rise && bit_r == BMI_LAST_BIT) begin
         unique case (state_r)
            BMI_DEV_ADDR: begin
               ack_r <= shift_r[6:0] == (BMI_ADDR_BASE | (7'(strap_r) << (BMI_STRAP_BIT - 1)));
               rd_r  <= (sda_s == BMI_DIR_READ);
            end
            BMI_WR_DATA: begin
               ack_r <= !reg_protected;
            end
            default: begin
               ack_r <= 1'b1;
            end
         endcase
      end
   end

   // Register pointer, write strobe and write-cycle trigger
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         ptr_r     <= 8'h00;
         reg_wdata <= 8'h00;
         reg_we    <= 1'b0;
         wrote_r   <= 1'b0;
         tgl_r     <= 1'b0;
         data_r    <= 1'b0;
         dwr_r     <= 1'b0;
      end else begin
         reg_we <= 1'b0;
         if (start_ev) begin
            wrote_r <= 1'b0;
            data_r  <= 1'b0;
            dwr_r   <= 1'b0;
         end else if (stop_ev && state_r != BMI_IDLE) begin
            if (dwr_r) begin
               tgl_r <= !tgl_r;
            end
            wrote_r <= 1'b0;
            dwr_r   <= 1'b0;
         end
         if (scl_fall && state_r == BMI_REG_ADDR && bit_r == BMI_LAST_BIT && ack_r) begin
            ptr_r   <= shift_r;
            wrote_r <= 1'b1;
         end else if (scl_fall && state_r == BMI_WR_DATA && bit_r == BMI_LAST_BIT && ack_r) begin
            reg_wdata <= shift_r;
            reg_we    <= 1'b1;
            data_r    <= 1'b1;
            dwr_r     <= 1'b1;
         end else if (scl_fall && state_r == BMI_ACK_OUT && data_r) begin
            // Step after the strobe has used the old pointer
            ptr_r[BMI_PAGE_BITS-1:0] <= ptr_r[BMI_PAGE_BITS-1:0] + BMI_PAGE_BITS'(1);
            data_r                   <= 1'b0;
         end else if (scl_rise && state_r == BMI_ACK_IN && !sda_s) begin
            // Advance on the ack rise so the next byte is ready at the fall
            ptr_r <= ptr_r + 8'h01;
         end
      end
   end
   assign reg_addr = ptr_r;

   // Output pin: low drives the line, high releases it
   always_ff @(posedge link_clk) begin
      if (!link_rst_n) begin
         sda_out_r <= 1'b1;
      end else if (!port_on || state_nxt == BMI_IDLE || state_nxt == BMI_IGNORE) begin
         sda_out_r <= 1'b1;
      end else if (scl_fall) begin
         unique case (state_nxt)
            BMI_ACK_OUT: sda_out_r <= !ack_r;
            BMI_RD_DATA: sda_out_r <= (state_r == BMI_RD_DATA) ? reg_rdata[BMI_LAST_BIT - bit_r - 3'h1]
                                                               : reg_rdata[BMI_LAST_BIT];
            default:     sda_out_r <= 1'b1;
         endcase
      end
   end
   assign serial_data_out_pin = sda_out_r;

   chk_stop_idle: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      stop_ev |=> state_r == BMI_IDLE) else $error("stop did not return to idle");
   chk_off_release: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      !port_on |=> serial_data_out_pin) else $error("pin driven while port off");
   chk_nack_stop: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      (state_r == BMI_ACK_IN && scl_fall && !ack_r && port_on) |=> state_r == BMI_IGNORE)
      else $error("read went on after nack");
   chk_bad_addr: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      (state_r == BMI_DEV_ADDR && scl_fall && bit_r == BMI_LAST_BIT && !ack_r) |=> ##1 serial_data_out_pin)
      else $error("mismatched address acked");
   chk_ignore_rel: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      state_r == BMI_IGNORE |-> serial_data_out_pin) else $error("pin driven while ignoring");
   chk_read_msb: assert property (@(posedge link_clk) disable iff (!link_rst_n)
      (state_r == BMI_ACK_OUT && state_nxt == BMI_RD_DATA && scl_fall && port_on)
      |=> serial_data_out_pin == $past(reg_rdata[BMI_LAST_BIT])) else $error("read byte did not open with its MSB");
   cov_read: cover property (@(posedge link_clk) disable iff (!link_rst_n) state_r == BMI_ACK_IN && scl_fall && ack_r);
   cov_write: cover property (@(posedge link_clk) disable iff (!link_rst_n) reg_we);
   cov_wcycle: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(busy));
endmodule : bmi_slave
`default_nettype wire

// ==== src/bmi_pkg.sv ====
// Package of constants for the battery monitor serial slave port
`default_nettype none
package bmi_pkg;
   localparam logic [6:0] BMI_ADDR_BASE   = 7'h28;
   localparam int         BMI_STRAP_BIT   = 1;
   localparam int         BMI_PAGE_BITS   = 2;
   localparam int         BMI_BYTE_BITS   = 8;
   localparam logic [2:0] BMI_LAST_BIT    = 3'h7;
   localparam logic       BMI_DIR_READ    = 1'b1;
   localparam int         BMI_SYS_CLK_HZ  = 50_000_000;
   localparam int         BMI_WR_CYCLE_US = 100;
   localparam int         BMI_WR_CYCLES   = BMI_SYS_CLK_HZ / 1_000_000 * BMI_WR_CYCLE_US;
   localparam int         BMI_GLITCH_CNT  = 2;
   typedef enum logic [2:0] {
      BMI_IDLE, BMI_DEV_ADDR, BMI_ACK_OUT, BMI_REG_ADDR, BMI_WR_DATA, BMI_RD_DATA, BMI_ACK_IN, BMI_IGNORE
   } bmi_state_t;
endpackage : bmi_pkg
`default_nettype wire

// ==== src/bmi_sync.sv ====
// Three-flop synchroniser with agreement filter on the link clock
`default_nettype none
module bmi_sync #(
   parameter logic INIT = 1'b1
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Data
   input  wire logic din,
   output var  logic dout
);
   logic [2:0] sh_r;
   logic       dout_r;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sh_r <= {3{INIT}};
      end else begin
         sh_r <= {sh_r[1:0], din};
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         dout_r <= INIT;
      end else if (sh_r[1] == sh_r[2]) begin
         dout_r <= sh_r[2];
      end
   end
   assign dout = dout_r;
endmodule : bmi_sync
`default_nettype wire

// ==== src/bmi_wcycle.sv ====
// Internal write cycle timer on the system clock, started by a toggle
`default_nettype none
module bmi_wcycle #(
   parameter int CYCLES = 5000
) (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic rst_n,
   // Start toggle from link domain
   input  wire logic start_tgl,
   // Busy level
   output var  logic busy
);
   logic [2:0]  tg_r;
   logic [31:0] cnt_r;
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         tg_r <= 3'h0;
      end else begin
         tg_r <= {tg_r[1:0], start_tgl};
      end
   end
   always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
         cnt_r <= 32'h0;
      end else if (tg_r[2] != tg_r[1]) begin
         cnt_r <= 32'(CYCLES);
      end else if (cnt_r != 32'h0) begin
         cnt_r <= cnt_r - 32'h1;
      end
   end
   assign busy = (cnt_r != 32'h0);
endmodule : bmi_wcycle
`default_nettype wire

// ==== dv/bmi_master.sv ====
// Bus master model: drives the serial clock and releases data open-drain style
`default_nettype none
module bmi_master (
   // Bus lines
   output var  logic scl,
   output var  logic sda_m,
   input  wire logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   // Quarter of a 400kHz bus clock period
   localparam time Q = 625ns;
   initial begin
      scl   = 1'b1;
      sda_m = 1'b1;
   end
   // Data moves only while the clock is low; sampled mid-high
   task automatic bit_x(input logic b, output logic r);
      sda_m = b;
      #Q scl = 1'b1;
      #Q r = sda;
      #Q scl = 1'b0;
      #Q;
   endtask : bit_x
   task automatic start_c;
      sda_m = 1'b1;
      #Q scl = 1'b1;
      #Q sda_m = 1'b0;
      #Q scl = 1'b0;
      #Q;
   endtask : start_c
   task automatic stop_c;
      sda_m = 1'b0;
      #Q scl = 1'b1;
      #Q sda_m = 1'b1;
      #Q;
   endtask : stop_c
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], r);
      bit_x(1'b1, r);
      ack = ~r;
   endtask : wr_byte
   task automatic rd_byte(input logic ack, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'b1, r);
         d[i] = r;
      end
      bit_x(~ack, r);
   endtask : rd_byte
endmodule : bmi_master
`default_nettype wire

// ==== dv/tb_bmi_slave.sv ====
// Testbench for the battery monitor serial slave port
`default_nettype none
module tb_bmi_slave;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WRC = 1500;
   logic       sys_clk    = 1'b0;
   logic       link_clk   = 1'b0;
   logic       rst_n      = 1'b0;
   logic       powerdown  = 1'b0;
   logic       addr_strap = 1'b0;
   logic       scl, sda_m, sdo, reg_we, reg_protected, write_busy;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
   logic [7:0] mem [256];
   int         error_cnt  = 0;
   int         n_compared = 0;
   // Pulled-up wire shared by both open-drain parties
   wire        sda = sda_m & sdo;
   always #10 sys_clk = ~sys_clk;
   initial begin
      #3;
      forever #6 link_clk = ~link_clk;
   end
   // Register store: pattern content, upper region protected
   assign reg_rdata     = mem[reg_addr];
   assign reg_protected = reg_addr >= 8'h58;
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3C;
   always @(posedge link_clk) if (reg_we) mem[reg_addr] <= reg_wdata;
   bmi_master m (.scl(scl), .sda_m(sda_m), .sda(sda));
   bmi_slave #(.WR_CYCLES(WRC)) uut (
      .sys_clk(sys_clk), .rst_n(rst_n), .link_clk(link_clk), .link_rst_n(rst_n),
      .powerdown(powerdown), .addr_strap(addr_strap), .scl_pin(scl),
      .serial_data_in_pin(sda), .serial_data_out_pin(sdo), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_rdata(reg_rdata),
      .reg_protected(reg_protected), .write_busy(write_busy));
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic ack_w(input string what, input logic [7:0] b, input logic exp);
      logic ack;
      m.wr_byte(b, ack);
      chk(what, {7'h00, exp}, {7'h00, ack});
   endtask : ack_w
   task automatic wait_busy(input logic v);
      int n = 0;
      while (write_busy !== v && n < WRC + 500) begin
         @(posedge sys_clk);
         n++;
      end
      chk("write_busy", {7'h00, v}, {7'h00, write_busy});
   endtask : wait_busy
   task automatic t_write;
      m.start_c();
      ack_w("addr", 8'h50, 1'b1);
      ack_w("reg", 8'h05, 1'b1);
      ack_w("data", 8'hA5, 1'b1);
      m.stop_c();
      wait_busy(1'b1);
      m.start_c();
      ack_w("busy addr", 8'h50, 1'b0);
      m.stop_c();
      wait_busy(1'b0);
      chk("stored", 8'hA5, mem[5]);
      $display("test write done");
   endtask : t_write
   task automatic t_read;
      m.start_c();
      ack_w("addr", 8'h50, 1'b1);
      ack_w("reg", 8'h04, 1'b1);
      m.start_c();
      ack_w("read addr", 8'h51, 1'b1);
      m.rd_byte(1'b1, d);
      chk("rd0", 8'h38, d);
      m.rd_byte(1'b0, d);
      chk("rd1", 8'hA5, d);
      m.stop_c();
      chk("released", 8'h01, {7'h00, sdo});
      $display("test read done");
   endtask : t_read
   task automatic t_page;
      m.start_c();
      ack_w("addr", 8'h50, 1'b1);
      ack_w("reg", 8'h0E, 1'b1);
      ack_w("pg0", 8'h11, 1'b1);
      ack_w("pg1", 8'h22, 1'b1);
      ack_w("pg2", 8'h33, 1'b1);
      m.stop_c();
      wait_busy(1'b1);
      wait_busy(1'b0);
      chk("page e", 8'h11, mem[8'h0E]);
      chk("page f", 8'h22, mem[8'h0F]);
      chk("page c", 8'h33, mem[8'h0C]);
      $display("test page done");
   endtask : t_page
   task automatic t_refuse;
      m.start_c();
      ack_w("other addr", 8'h52, 1'b0);
      m.stop_c();
      m.start_c();
      ack_w("addr", 8'h50, 1'b1);
      ack_w("reg", 8'h60, 1'b1);
      ack_w("protected", 8'h11, 1'b0);
      m.stop_c();
      wait_busy(1'b0);
      chk("unchanged", 8'h5C, mem[8'h60]);
      $display("test refuse done");
   endtask : t_refuse
   task automatic t_strap;
      @(posedge sys_clk);
      #1 powerdown = 1'b1;
      addr_strap = 1'b1;
      m.start_c();
      ack_w("powerdown", 8'h52, 1'b0);
      m.stop_c();
      @(posedge sys_clk);
      #1 powerdown = 1'b0;
      repeat (20) @(posedge sys_clk);
      m.start_c();
      ack_w("strap high", 8'h53, 1'b1);
      m.rd_byte(1'b0, d);
      chk("strap rd", 8'h5C, d);
      m.stop_c();
      chk("released", 8'h01, {7'h00, sdo});
      $display("test strap done");
   endtask : t_strap
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      #1ms;
      error_cnt++;
      end_sim();
   end
   initial begin
      repeat (4) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      repeat (20) @(posedge sys_clk);
      chk("idle out", 8'h01, {7'h00, sdo});
      t_write();
      t_read();
      t_page();
      t_refuse();
      t_strap();
      end_sim();
   end
endmodule : tb_bmi_slave
`default_nettype wire
